// >>> cbtd_decoder.sv
// branch, trap and long-branch decode and execute for the compact set
`timescale 1ns/10ps
module cbtd_decoder (
    // clock and reset
    input  wire logic                               clock,
    input  wire logic                               rst_n,
    // instruction issue
    input  wire logic                               instr_valid,
    input  wire logic [15:0]                        instr,
    input  wire logic [cbtd_pkg::CBTD_XLEN-1:0]     instr_addr,
    // core state
    input  wire logic [cbtd_pkg::CBTD_XLEN-1:0]     current_status_flags,
    input  wire logic [cbtd_pkg::CBTD_XLEN-1:0]     link_register_in,
    // results
    output logic                                    busy,
    output logic                                    done,
    output logic                                    pc_write,
    output logic [cbtd_pkg::CBTD_XLEN-1:0]          pc_out,
    output logic                                    link_write,
    output logic [cbtd_pkg::CBTD_XLEN-1:0]          link_register,
    output logic                                    status_write,
    output logic [cbtd_pkg::CBTD_XLEN-1:0]          status_out,
    output logic                                    saved_write,
    output logic [cbtd_pkg::CBTD_XLEN-1:0]          saved_status_copy,
    output logic                                    undef_trap
);
    import cbtd_pkg::*;

    localparam int W = CBTD_XLEN;

    cbtd_kind_t           kind;
    logic       [3:0]     cond;
    logic       [7:0]     signed_halfword_offset_field;
    logic       [10:0]    eleven_bit_offset_field;
    logic       [7:0]     trap_comment_field;
    logic                 cond_pass;
    logic       [W-1:0]   pc_ahead;
    logic       [W-1:0]   next_addr;
    logic       [W-1:0]   cond_off;
    logic       [W-1:0]   uncond_off;
    logic       [W-1:0]   long_hi_off;
    logic       [W-1:0]   long_lo_off;
    cbtd_state_t          state_reg;
    logic       [1:0]     count_reg;
    logic       [1:0]     count_next;
    logic                 start;

    // classify by fixed upper opcode bits before any field is used
    function automatic cbtd_kind_t classify(input logic [15:0] op);
        cbtd_kind_t k;
        k = CBTD_K_NONE;
        if (op[15:12] == CBTD_OP_COND) begin
            if (op[11:8] == CBTD_COND_TRAP) begin
                k = CBTD_K_TRAP;
            end else if (op[11:8] == CBTD_COND_UNDEF) begin
                k = CBTD_K_UNDEF;
            end else begin
                k = CBTD_K_COND;
            end
        end else if (op[15:11] == CBTD_OP_UNCOND) begin
            k = CBTD_K_UNCOND;
        end else if (op[15:12] == CBTD_OP_LONG) begin
            k = op[11] ? CBTD_K_LONG2 : CBTD_K_LONG1;
        end
        return k;
    endfunction

    assign kind                         = classify(instr);
    assign cond                         = instr[11:8];
    assign signed_halfword_offset_field = instr[7:0];
    assign eleven_bit_offset_field      = instr[10:0];
    // comment byte has no effect on execution
    assign trap_comment_field           = instr[7:0];

    cbtd_cond_eval u_cond (
        .cond   (cond),
        .flag_n (current_status_flags[31]),
        .flag_z (current_status_flags[30]),
        .flag_c (current_status_flags[29]),
        .flag_v (current_status_flags[28]),
        .pass   (cond_pass)
    );

    assign pc_ahead    = instr_addr + CBTD_PREFETCH;
    assign next_addr   = instr_addr + CBTD_HALFWORD;
    assign cond_off    = {{(W-9){signed_halfword_offset_field[7]}}, signed_halfword_offset_field, 1'b0};
    assign uncond_off  = {{(W-12){eleven_bit_offset_field[10]}}, eleven_bit_offset_field, 1'b0};
    assign long_hi_off = {{(W-23){eleven_bit_offset_field[10]}}, eleven_bit_offset_field, 12'h000};
    assign long_lo_off = {{(W-12){1'b0}}, eleven_bit_offset_field, 1'b0};

    assign start = instr_valid && (state_reg == CBTD_IDLE) && (kind != CBTD_K_NONE);

    // cycle budget mirrors the full-width equivalents
    always_comb begin
        case (kind)
            CBTD_K_COND:   count_next = cond_pass ? CBTD_CYC_TAKEN : CBTD_CYC_UNTAKEN;
            CBTD_K_TRAP:   count_next = CBTD_CYC_TRAP;
            CBTD_K_UNDEF:  count_next = CBTD_CYC_TRAP;
            CBTD_K_UNCOND: count_next = CBTD_CYC_TAKEN;
            CBTD_K_LONG1:  count_next = CBTD_CYC_LONG1;
            CBTD_K_LONG2:  count_next = CBTD_CYC_LONG2;
            default:       count_next = 2'h1;
        endcase
    end

    // sequencer: results post on the last cycle of the budget
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= CBTD_IDLE;
            count_reg <= 2'h0;
        end else begin
            case (state_reg)
                CBTD_IDLE: begin
                    if (start) begin
                        state_reg <= CBTD_BUSY;
                        count_reg <= count_next - 2'h1;
                    end
                end
                CBTD_BUSY: begin
                    if (count_reg == 2'h0) begin
                        state_reg <= CBTD_IDLE;
                    end else begin
                        count_reg <= count_reg - 2'h1;
                    end
                end
                default: state_reg <= CBTD_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
        end else if (start && count_next != 2'h1) begin
            busy <= 1'b1;
        end else if (state_reg == CBTD_BUSY && count_reg == 2'h1) begin
            busy <= 1'b0;
        end else if (state_reg == CBTD_IDLE) begin
            busy <= 1'b0;
        end
    end

    // computed results are held until the budget expires
    logic           res_pc_w;
    logic           res_lr_w;
    logic           res_trap;
    logic           res_undef;
    logic [W-1:0]   res_pc;
    logic [W-1:0]   res_lr;
    logic [W-1:0]   res_status;
    logic [W-1:0]   res_saved;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            res_pc_w   <= 1'b0;
            res_lr_w   <= 1'b0;
            res_trap   <= 1'b0;
            res_undef  <= 1'b0;
            res_pc     <= CBTD_PC_RESET;
            res_lr     <= '0;
            res_status <= '0;
            res_saved  <= '0;
        end else if (start) begin
            res_pc_w   <= 1'b0;
            res_lr_w   <= 1'b0;
            res_trap   <= 1'b0;
            res_undef  <= 1'b0;
            res_pc     <= next_addr;
            res_lr     <= link_register_in;
            res_status <= current_status_flags;
            // snapshot at issue: flags may move before the budget expires
            res_saved  <= current_status_flags;
            case (kind)
                CBTD_K_COND: begin
                    // untaken leaves every register alone
                    res_pc_w <= cond_pass;
                    res_pc   <= pc_ahead + cond_off;
                end
                CBTD_K_TRAP: begin
                    res_trap   <= 1'b1;
                    res_pc_w   <= 1'b1;
                    res_pc     <= CBTD_TRAP_VECTOR;
                    res_lr_w   <= 1'b1;
                    res_lr     <= next_addr;
                    // clear state bit 5 for full-width, set supervisor mode
                    res_status <= {current_status_flags[W-1:6], 1'b0, CBTD_MODE_SUPER};
                end
                CBTD_K_UNDEF: begin
                    // reserved encoding: flagged to the core, nothing written
                    res_undef <= 1'b1;
                end
                CBTD_K_UNCOND: begin
                    res_pc_w <= 1'b1;
                    res_pc   <= pc_ahead + uncond_off;
                end
                CBTD_K_LONG1: begin
                    res_lr_w <= 1'b1;
                    res_lr   <= pc_ahead + long_hi_off;
                end
                CBTD_K_LONG2: begin
                    res_pc_w <= 1'b1;
                    res_pc   <= link_register_in + long_lo_off;
                    res_lr_w <= 1'b1;
                    res_lr   <= next_addr | 32'h0000_0001;
                end
                default: res_pc_w <= 1'b0;
            endcase
        end
    end

    logic finish;
    assign finish = (state_reg == CBTD_BUSY) && (count_reg == 2'h0);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            done         <= 1'b0;
            pc_write     <= 1'b0;
            link_write   <= 1'b0;
            status_write <= 1'b0;
            saved_write  <= 1'b0;
            undef_trap   <= 1'b0;
        end else begin
            done         <= finish;
            pc_write     <= finish & res_pc_w;
            link_write   <= finish & res_lr_w;
            status_write <= finish & res_trap;
            saved_write  <= finish & res_trap;
            undef_trap   <= finish & res_undef;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pc_out            <= CBTD_PC_RESET;
            link_register     <= '0;
            status_out        <= '0;
            saved_status_copy <= '0;
        end else if (finish) begin
            pc_out            <= res_pc;
            link_register     <= res_lr;
            status_out        <= res_status;
            saved_status_copy <= res_saved;
        end
    end
endmodule

// >>> cbtd_pkg.sv
// constants and types for the compact branch and trap decoder
//
// Contract
// - targets use pc four bytes ahead
// - code 0000 zero set, 0001 clear
// - code 0010 carry set, 0011 clear
// - code 0100 negative set, 0101 clear
// - code 0110 overflow set, 0111 clear
// - 1000 carry and not zero; 1001 inverse
// - 1010 negative equals overflow; 1011 differs
// - 1100 greater than; 1101 less or equal
// - conditional offset sign-extended, doubled
// - code 1110 unused; 1111 is trap
// - trap saves link, status, vectors to 0x8
// - trap comment field is ignored
// - cycle counts match full-width counterparts
// - unconditional offset eleven bits, doubled, signed
// - long branch first half: link = pc+off<<12
package cbtd_pkg;
    localparam int          CBTD_XLEN         = 32;
    localparam logic [31:0] CBTD_PREFETCH     = 32'h0000_0004;
    localparam logic [31:0] CBTD_HALFWORD     = 32'h0000_0002;
    localparam logic [31:0] CBTD_TRAP_VECTOR  = 32'h0000_0008;
    localparam logic [4:0]  CBTD_MODE_SUPER   = 5'h13;
    localparam logic [4:0]  CBTD_MODE_RESET   = 5'h13;
    localparam logic [3:0]  CBTD_COND_UNDEF   = 4'he;
    localparam logic [3:0]  CBTD_COND_TRAP    = 4'hf;
    // opcode tags in the upper halfword bits
    localparam logic [3:0]  CBTD_OP_COND      = 4'hd;
    localparam logic [4:0]  CBTD_OP_UNCOND    = 5'h1c;
    localparam logic [3:0]  CBTD_OP_LONG      = 4'hf;
    // execution cycles: branch takes 3, untaken 1, trap 3
    localparam logic [1:0]  CBTD_CYC_TAKEN    = 2'h3;
    localparam logic [1:0]  CBTD_CYC_UNTAKEN  = 2'h1;
    localparam logic [1:0]  CBTD_CYC_TRAP     = 2'h3;
    localparam logic [1:0]  CBTD_CYC_LONG1    = 2'h1;
    localparam logic [1:0]  CBTD_CYC_LONG2    = 2'h3;
    localparam logic [31:0] CBTD_PC_RESET     = 32'h0000_0000;

    typedef enum logic [2:0] {
        CBTD_K_NONE, CBTD_K_COND, CBTD_K_TRAP, CBTD_K_UNDEF,
        CBTD_K_UNCOND, CBTD_K_LONG1, CBTD_K_LONG2
    } cbtd_kind_t;

    typedef enum {CBTD_IDLE, CBTD_BUSY} cbtd_state_t;
endpackage

// >>> cbtd_cond_eval.sv
// evaluates a four-bit branch condition against the flags
`timescale 1ns/10ps
module cbtd_cond_eval (
    // condition and flags
    input  wire logic [3:0] cond,
    input  wire logic       flag_n,
    input  wire logic       flag_z,
    input  wire logic       flag_c,
    input  wire logic       flag_v,
    // verdict
    output logic            pass
);
    logic base;
    always_comb begin
        case (cond[3:1])
            3'h0:    base = flag_z;
            3'h1:    base = flag_c;
            3'h2:    base = flag_n;
            3'h3:    base = flag_v;
            3'h4:    base = flag_c & ~flag_z;
            3'h5:    base = ~(flag_n ^ flag_v);
            3'h6:    base = ~flag_z & ~(flag_n ^ flag_v);
            default: base = 1'b0;
        endcase
        // odd codes are the inverse of their even partner
        pass = base ^ cond[0];
    end
endmodule

// >>> cbtd_decoder_sva.sv
// concurrent checks on the branch and trap decoder ports
`timescale 1ns/10ps
module cbtd_decoder_sva (
    // clock and reset
    input wire logic        clock,
    input wire logic        rst_n,
    // issue side
    input wire logic        instr_valid,
    input wire logic [15:0] instr,
    input wire logic [31:0] instr_addr,
    input wire logic [31:0] current_status_flags,
    input wire logic [31:0] link_register_in,
    // results
    input wire logic        busy,
    input wire logic        done,
    input wire logic        pc_write,
    input wire logic [31:0] pc_out,
    input wire logic        link_write,
    input wire logic [31:0] link_register,
    input wire logic        status_write,
    input wire logic [31:0] status_out,
    input wire logic        saved_write,
    input wire logic [31:0] saved_status_copy,
    input wire logic        undef_trap
);
    import cbtd_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic        take;
    logic [15:0] cap_instr_reg;
    logic [31:0] cap_addr_reg;
    logic [31:0] cap_status_reg;
    assign take = instr_valid && !busy;
    // snapshot at the take edge, since the issue inputs move on afterwards
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cap_instr_reg  <= 16'h0;
            cap_addr_reg   <= 32'h0;
            cap_status_reg <= 32'h0;
        end else if (take) begin
            cap_instr_reg  <= instr;
            cap_addr_reg   <= instr_addr;
            cap_status_reg <= current_status_flags;
        end
    end
    sequence beq_take; take && instr[15:8] == 8'hd0 && current_status_flags[30]; endsequence
    sequence bne_skip; take && instr[15:8] == 8'hd1 && current_status_flags[30]; endsequence
    sequence uncond_take; take && instr[15:11] == CBTD_OP_UNCOND; endsequence
    sequence long1_take; take && instr[15:11] == 5'h1e; endsequence
    sequence trap_take; take && instr[15:8] == {CBTD_OP_COND, CBTD_COND_TRAP}; endsequence
    sequence quiet3; !done [*3]; endsequence
    done_pulse_a: assert property (done |=> !done) else $error("done longer than one cycle");
    strobe_done_a: assert property ((pc_write || link_write || status_write || saved_write) |-> done)
        else $error("write strobe without done");
    beq_target_a: assert property (beq_take |=> quiet3 ##1 (done && pc_write && pc_out ==
        cap_addr_reg + CBTD_PREFETCH + {{23{cap_instr_reg[7]}}, cap_instr_reg[7:0], 1'b0}))
        else $error("taken conditional target or timing wrong");
    untaken_fast_a: assert property (bne_skip |=> !done ##1 (done && !link_write && !status_write))
        else $error("untaken branch timing or side effect wrong");
    uncond_target_a: assert property (uncond_take |=> quiet3 ##1 (done && pc_write && pc_out ==
        cap_addr_reg + CBTD_PREFETCH + {{20{cap_instr_reg[10]}}, cap_instr_reg[10:0], 1'b0}))
        else $error("unconditional target or timing wrong");
    long_first_a: assert property (long1_take |=> !done ##1 (done && link_write && !pc_write &&
        link_register == cap_addr_reg + CBTD_PREFETCH + {{9{cap_instr_reg[10]}}, cap_instr_reg[10:0], 12'h0}))
        else $error("first long half wrong");
    trap_entry_a: assert property (trap_take |-> ##4 (pc_write && pc_out == CBTD_TRAP_VECTOR &&
        link_write && link_register == cap_addr_reg + CBTD_HALFWORD)) else $error("trap entry wrong");
    trap_status_a: assert property (status_write |-> saved_write && saved_status_copy == cap_status_reg &&
        status_out[4:0] == CBTD_MODE_SUPER && !status_out[5]) else $error("trap status wrong");
    undef_quiet_a: assert property (undef_trap |-> !(pc_write || link_write || status_write || saved_write))
        else $error("reserved code wrote state");
endmodule
bind cbtd_decoder cbtd_decoder_sva cbtd_decoder_sva_i (
    .clock(clock), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr), .instr_addr(instr_addr),
    .current_status_flags(current_status_flags), .link_register_in(link_register_in), .busy(busy),
    .done(done), .pc_write(pc_write), .pc_out(pc_out), .link_write(link_write),
    .link_register(link_register), .status_write(status_write), .status_out(status_out),
    .saved_write(saved_write), .saved_status_copy(saved_status_copy), .undef_trap(undef_trap));

// >>> tb_compact_branch_trap_decoder.sv
// self-checking bench for the branch and trap decoder
`timescale 1ns/10ps
module tb_compact_branch_trap_decoder;
    import cbtd_pkg::*;
    logic        clock, rst_n, instr_valid, busy, done, pc_write, link_write;
    logic        status_write, saved_write, undef_trap, undef_seen;
    logic [15:0] instr;
    logic [31:0] instr_addr, current_status_flags, link_register_in;
    logic [31:0] pc_out, link_register, status_out, saved_status_copy, adr, st;
    int          fails, check_count, cycles;
    cbtd_decoder cbtd_decoder_i (
        .clock(clock), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr), .instr_addr(instr_addr),
        .current_status_flags(current_status_flags), .link_register_in(link_register_in), .busy(busy),
        .done(done), .pc_write(pc_write), .pc_out(pc_out), .link_write(link_write),
        .link_register(link_register), .status_write(status_write), .status_out(status_out),
        .saved_write(saved_write), .saved_status_copy(saved_status_copy), .undef_trap(undef_trap));
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic bit cond_ok(input logic [3:0] cc, input logic [31:0] s);
        bit n, z, c, v, r;
        {n, z, c, v} = s[31:28];
        case (cc[3:1])
            3'h0: r = z;
            3'h1: r = c;
            3'h2: r = n;
            3'h3: r = v;
            3'h4: r = c & ~z;
            3'h5: r = n == v;
            default: r = ~z & (n == v);
        endcase
        return r ^ cc[0];
    endfunction
    // issues one halfword and counts edges from take to done, 12 if never answered
    task automatic run(input logic [15:0] ins, input logic [31:0] a, input logic [31:0] s, input logic [31:0] lnk);
        int n;
        logic b0;
        @(posedge clock);
        #1 {instr_valid, instr, instr_addr, current_status_flags, link_register_in} = {1'b1, ins, a, s, lnk};
        @(posedge clock);
        #1 instr_valid = 1'b0;
        b0 = busy;
        n = 0;
        undef_seen = 1'b0;
        while (done !== 1'b1 && n < 12) begin
            @(posedge clock);
            #1 n++;
            undef_seen = undef_seen | undef_trap;
        end
        if (ins[15:12] == CBTD_OP_COND && ins[11:8] < CBTD_COND_UNDEF) begin
            chk(32'(n), cond_ok(ins[11:8], s) ? 32'(CBTD_CYC_TAKEN) : 32'(CBTD_CYC_UNTAKEN));
            chk(32'(b0), 32'(cond_ok(ins[11:8], s)));
            chk({28'h0, pc_write, link_write, status_write, saved_write}, {28'h0, cond_ok(ins[11:8], s), 3'h0});
            if (cond_ok(ins[11:8], s))
                chk(pc_out, a + 32'h4 + {{23{ins[7]}}, ins[7:0], 1'b0});
        end else if (ins[15:8] == 8'hde) begin
            chk({28'h0, undef_seen, pc_write, link_write, status_write}, 32'h8);
            chk(32'(b0), 32'h1);
        end else if (ins[15:8] == 8'hdf) begin
            chk(32'(n), 32'(CBTD_CYC_TRAP));
            chk(32'(b0), 32'h1);
            chk({28'h0, pc_write, link_write, status_write, saved_write}, 32'hf);
            chk(pc_out, CBTD_TRAP_VECTOR);
            chk(link_register, a + 32'h2);
            chk(saved_status_copy, s);
            chk(status_out, {s[31:6], 1'b0, 5'h13});
        end else if (ins[15:11] == CBTD_OP_UNCOND) begin
            chk(32'(n), 32'(CBTD_CYC_TAKEN));
            chk(32'(b0), 32'h1);
            chk(pc_out, a + 32'h4 + {{20{ins[10]}}, ins[10:0], 1'b0});
        end else if (ins[15:11] == 5'h1e) begin
            chk({29'h0, n[1:0], pc_write}, {29'h0, CBTD_CYC_LONG1, 1'b0});
            chk(32'(b0), 32'h0);
            chk(link_register, a + 32'h4 + {{9{ins[10]}}, ins[10:0], 12'h0});
        end else if (ins[15:11] == 5'h1f) begin
            chk(32'(n), 32'(CBTD_CYC_LONG2));
            chk(pc_out, lnk + {20'h0, ins[10:0], 1'b0});
            chk(link_register, (a + 32'h2) | 32'h1);
        end else begin
            chk(32'(n), 32'd12);
            chk(32'(b0), 32'h0);
        end
    endtask
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 8000) begin
            fails++;
            wrap_up();
        end
    end
    initial begin
        {rst_n, instr_valid, instr, instr_addr, current_status_flags, link_register_in} = '0;
        void'($urandom(32'h219c));
        repeat (4) @(posedge clock);
        #1 rst_n = 1'b1;
        run(16'hd080, 32'h100, 32'h4000_0000, 32'h0);
        run(16'hd1fe, 32'h300, 32'h4000_0000, 32'h0);
        run(16'he400, 32'h1000, 32'h0, 32'h0);
        run(16'hb000, 32'h200, 32'h0, 32'h0);
        for (int i = 0; i < 64; i++) begin
            adr = $urandom & 32'h00ff_fffe;
            st = $urandom;
            run({4'hd, 4'(i), 8'($urandom)}, adr, st, 32'h0);
            run({5'h1c, 11'($urandom)}, adr, st, 32'h0);
            run({5'h1e, 11'($urandom)}, adr, st, 32'h0);
            run({5'h1f, 11'($urandom)}, adr + 32'h2, st, link_register);
        end
        wrap_up();
    end
endmodule
